// [inc/adc_ctl_defs.svh]
// timing counts and field positions for the converter control link
// assumes a 250 MHz core clock (4 ns period)
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

`define CLK_PERIOD_NS 4
// faster grade step interval and decision point, in ns
`define STEP_NS 950
`define DECIDE_NS 850
// rounded down: longest times
`define STEP_CYC (`STEP_NS / `CLK_PERIOD_NS)
`define DECIDE_CYC (`DECIDE_NS / `CLK_PERIOD_NS)
// lead of data valid before status falls, least figure rounded up
`define LEAD_NS 25
`define LEAD_CYC ((`LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// hold of data after read/convert low, rounded up
`define HOLD_NS 25
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// host pulse widths on read/convert select
`define LOW_PULSE_NS 50
`define HIGH_PULSE_NS 150
`define LOW_PULSE_CYC ((`LOW_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIGH_PULSE_CYC ((`HIGH_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_BITS 12
`define SHORT_BITS 8
`define BYTE_HI_MSB 11
`define BYTE_HI_LSB 4
`define NIBBLE_MSB 3

`endif

// [inc/adc_ctl_pkg.sv]
// types shared by both ends of the converter control link
// assumes adc_ctl_defs.svh for numeric constants
package adc_ctl_pkg;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_STEP = 2'b01,
        CONV_LEAD = 2'b10
    } conv_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_CONV_LOW = 3'b001,
        HOST_WAIT = 3'b010,
        HOST_READ_A = 3'b011,
        HOST_GAP = 3'b100,
        HOST_READ_B = 3'b101,
        HOST_DONE = 3'b110
    } host_state_e;
endpackage

// [inc/adc_ctl_if.sv]
// control pins between processor side and converter
// data bus resolution from enables is left to the bench
`timescale 1ns/10ps
`default_nettype none
interface adc_ctl_if;
    logic chipActive;
    logic deviceSelN;
    logic readConvSel;
    logic wordWidthSel;
    logic byteAndLengthSelect;
    logic conversionStatus;
    logic [11:0] dataOut;
    logic [11:0] dataOe;

    modport device (
        input chipActive, deviceSelN, readConvSel, wordWidthSel, byteAndLengthSelect,
        output conversionStatus, dataOut, dataOe
    );
    modport host (
        output chipActive, deviceSelN, readConvSel, wordWidthSel, byteAndLengthSelect,
        input conversionStatus, dataOut, dataOe
    );
endinterface
`default_nettype wire

// [logic/adc_conversion_control.sv]
// converter end: conversion sequencing, status and three-state data lanes
// assumes control pins arrive asynchronously; comparator is a plain input bit
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defs.svh"

//  Function
// - step trial code every step interval
// - take comparator decision after settle delay
// - processor control or stand-alone via read/convert
// - 8/12-bit conversion, left-justified, 12 or 8+4 read
// - stand-alone: host straps pins, 12-bit words
// - data readable when read high, status low
// - host keeps read/convert low/high minimum widths
// - data valid a lead before status falls (result latched then, but lanes are enabled only once status is low)
// - hold data briefly after read/convert low
// - status high only converting; ignore restarts
// - start when last start condition becomes active
// - latch length select; 8-bit pads 1000
// - byte mode: 8 MSBs or nibble plus zeros
module adc_conversion_control
    import adc_ctl_pkg::*;
#(
    parameter int STEP_CYCLES = `STEP_CYC,
    parameter int DECIDE_CYCLES = `DECIDE_CYC,
    parameter int LEAD_CYCLES = `LEAD_CYC,
    parameter int HOLD_CYCLES = `HOLD_CYC
) (
    input wire logic core_clk,           // core clock
    input wire logic rstn,               // async reset, low
    adc_ctl_if.device link,              // control pins
    input wire logic comparatorHigh,     // comparator: input above trial code
    output logic [11:0] trialCode,       // code to the dac
    output logic convBusy                // conversion in progress
);
    logic [1:0] ceSync, csSync, rcSync, wwSync, abSync;
    logic ce, csN, rc, ww, ab;
    logic startCond, startCondD;
    conv_state_e state;
    logic [11:0] searchReg;
    logic [11:0] resultReg;
    logic [3:0] bitIdx;
    logic [15:0] stepCnt;
    logic shortLen;
    logic statusReg;
    logic readEn;
    logic [7:0] holdCnt;
    logic [11:0] oeNext;
    logic [11:0] oeReg;
    logic [11:0] dataReg;

    // two-stage synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ceSync <= 2'h0;
            csSync <= 2'h3;
            rcSync <= 2'h3;
            wwSync <= 2'h3;
            abSync <= 2'h0;
        end else begin
            ceSync <= {ceSync[0], link.chipActive};
            csSync <= {csSync[0], link.deviceSelN};
            rcSync <= {rcSync[0], link.readConvSel};
            wwSync <= {wwSync[0], link.wordWidthSel};
            abSync <= {abSync[0], link.byteAndLengthSelect};
        end
    end
    assign ce = ceSync[1];
    assign csN = csSync[1];
    assign rc = rcSync[1];
    assign ww = wwSync[1];
    assign ab = abSync[1];

    // start is the rising edge of the combined condition, whichever input came last
    assign startCond = ce && !csN && !rc;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            startCondD <= 1'b0;
        end else begin
            startCondD <= startCond;
        end
    end

    // successive approximation sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= CONV_IDLE;
            searchReg <= 12'h000;
            resultReg <= 12'h000;
            bitIdx <= 4'h0;
            stepCnt <= 16'h0000;
            shortLen <= 1'b0;
            statusReg <= 1'b0;
        end else begin
            unique case (state)
                CONV_IDLE: begin
                    // restarts are only looked at here, so busy ignores them
                    if (startCond && !startCondD) begin
                        shortLen <= ab;
                        searchReg <= 12'h800;
                        bitIdx <= 4'hb;
                        stepCnt <= 16'h0000;
                        statusReg <= 1'b1;
                        state <= CONV_STEP;
                    end
                end
                CONV_STEP: begin
                    stepCnt <= stepCnt + 16'h0001;
                    if (stepCnt == 16'(DECIDE_CYCLES - 1)) begin
                        searchReg[bitIdx] <= comparatorHigh;
                    end
                    if (stepCnt == 16'(STEP_CYCLES - 1)) begin
                        stepCnt <= 16'h0000;
                        if (bitIdx == 4'h0 || (shortLen && bitIdx == 4'h4)) begin
                            // 8-bit result: three zeros below a one in the low nibble
                            if (shortLen) begin
                                resultReg <= {searchReg[11:4], 4'h8};
                            end else begin
                                resultReg <= searchReg;
                            end
                            state <= CONV_LEAD;
                        end else begin
                            bitIdx <= bitIdx - 4'h1;
                            searchReg[bitIdx - 4'h1] <= 1'b1;
                        end
                    end
                end
                CONV_LEAD: begin
                    // result already latched; status drops after the lead
                    stepCnt <= stepCnt + 16'h0001;
                    if (stepCnt == 16'(LEAD_CYCLES - 1)) begin
                        statusReg <= 1'b0;
                        state <= CONV_IDLE;
                    end
                end
                default: begin
                    state <= CONV_IDLE;
                end
            endcase
        end
    end

    assign readEn = ce && !csN && rc && !statusReg;

    // hold timer keeps lanes driven briefly after read/convert falls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            holdCnt <= 8'h00;
        end else if (readEn) begin
            holdCnt <= 8'(HOLD_CYCLES);
        end else if (holdCnt != 8'h00) begin
            holdCnt <= holdCnt - 8'h01;
        end
    end

    // lane enables; byte lanes switch through one all-off cycle
    always_comb begin
        oeNext = 12'h000;
        if (readEn) begin
            if (ww) begin
                oeNext = 12'hfff;
            end else if (!ab) begin
                oeNext = 12'hff0;
            end else begin
                // upper four lanes off so a strapped byte bus never sees two drivers
                oeNext = 12'h0ff;
            end
        end else if (holdCnt != 8'h00) begin
            oeNext = oeReg;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oeReg <= 12'h000;
            dataReg <= 12'h000;
        end else begin
            // break before make: any change of lanes passes through all-off
            if (oeReg != 12'h000 && oeNext != oeReg) begin
                oeReg <= 12'h000;
            end else begin
                oeReg <= oeNext;
            end
            if (readEn) begin
                if (ww) begin
                    dataReg <= resultReg;
                end else if (!ab) begin
                    dataReg <= {resultReg[11:4], 4'h0};
                end else begin
                    dataReg <= {8'h00, resultReg[3:0]};
                end
            end
        end
    end

    assign link.dataOut = dataReg;
    assign link.dataOe = oeReg;
    assign link.conversionStatus = statusReg;
    assign trialCode = searchReg;
    assign convBusy = statusReg;
endmodule
`default_nettype wire

// [logic/adc_host_control.sv]
// processor end: drives the control pins, starts conversions, reads the result
// assumes the converter end sits on the same interface; status is asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defs.svh"

module adc_host_control
    import adc_ctl_pkg::*;
#(
    parameter int LOW_CYCLES = `LOW_PULSE_CYC,
    parameter int HIGH_CYCLES = `HIGH_PULSE_CYC
) (
    input wire logic core_clk,          // core clock
    input wire logic rstn,              // async reset, low
    adc_ctl_if.host link,               // control pins
    input wire logic standAlone,        // strap stand-alone style
    input wire logic shortConv,         // request 8-bit conversion
    input wire logic byteRead,          // read as 8 then 4
    input wire logic startReq,          // pulse: start a conversion
    output logic busy,                  // sequence in progress
    output logic [11:0] result,         // last result, left-justified
    output logic resultValid            // pulse: result updated
);
    logic [1:0] stsSync;
    logic sts;
    host_state_e state;
    logic [7:0] cnt;
    logic ceReg, csReg, rcReg, wwReg, abReg;
    logic [11:0] resultReg;
    logic validReg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stsSync <= 2'h0;
        end else begin
            stsSync <= {stsSync[0], link.conversionStatus};
        end
    end
    assign sts = stsSync[1];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= HOST_IDLE;
            cnt <= 8'h00;
            ceReg <= 1'b0;
            csReg <= 1'b1;
            rcReg <= 1'b1;
            wwReg <= 1'b1;
            abReg <= 1'b0;
            resultReg <= 12'h000;
            validReg <= 1'b0;
        end else begin
            validReg <= 1'b0;
            cnt <= cnt + 8'h01;
            unique case (state)
                HOST_IDLE: begin
                    if (startReq) begin
                        // stand-alone straps fixed levels, only read/convert moves
                        ceReg <= 1'b1;
                        csReg <= 1'b0;
                        wwReg <= standAlone ? 1'b1 : !byteRead;
                        abReg <= standAlone ? 1'b0 : shortConv;
                        rcReg <= 1'b0;
                        cnt <= 8'h00;
                        state <= HOST_CONV_LOW;
                    end
                end
                HOST_CONV_LOW: begin
                    if (cnt == 8'(LOW_CYCLES - 1)) begin
                        rcReg <= 1'b1;
                        cnt <= 8'h00;
                        state <= HOST_WAIT;
                    end
                end
                HOST_WAIT: begin
                    // status needs sync latency before it shows high
                    if (cnt > 8'h08 && !sts) begin
                        abReg <= 1'b0;
                        cnt <= 8'h00;
                        state <= HOST_READ_A;
                    end
                end
                HOST_READ_A: begin
                    if (cnt == 8'h06) begin
                        resultReg <= link.dataOut;
                        if (!wwReg) begin
                            abReg <= 1'b1;
                            cnt <= 8'h00;
                            state <= HOST_GAP;
                        end else begin
                            cnt <= 8'h00;
                            state <= HOST_DONE;
                        end
                    end
                end
                HOST_GAP: begin
                    if (cnt == 8'h06) begin
                        resultReg[3:0] <= link.dataOut[3:0];
                        cnt <= 8'h00;
                        state <= HOST_DONE;
                    end
                end
                HOST_DONE: begin
                    // high phase held at least its minimum before next start
                    if (cnt >= 8'(HIGH_CYCLES)) begin
                        validReg <= 1'b1;
                        abReg <= 1'b0;
                        state <= HOST_IDLE;
                    end
                end
                default: begin
                    state <= HOST_IDLE;
                end
            endcase
        end
    end

    assign link.chipActive = ceReg;
    assign link.deviceSelN = csReg;
    assign link.readConvSel = rcReg;
    assign link.wordWidthSel = wwReg;
    assign link.byteAndLengthSelect = abReg;
    assign busy = (state != HOST_IDLE);
    assign result = resultReg;
    assign resultValid = validReg;
endmodule
`default_nettype wire

// [test/adc_ctl_checker.sv]
// concurrent checks on the pins between the processor end and the converter end
// assumes one core clock and the async active-low reset of both ends
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defs.svh"
module adc_ctl_checker #(
    parameter int STEP_CYCLES = `STEP_CYC,
    parameter int LEAD_CYCLES = `LEAD_CYC
) (
    input wire logic core_clk,            // core clock
    input wire logic rstn,                // async reset, low
    input wire logic chipActive,          // chip active, high
    input wire logic deviceSelN,          // device select, low
    input wire logic readConvSel,         // 1 read, 0 convert
    input wire logic wordWidthSel,        // 1 twelve-bit output
    input wire logic byteAndLengthSelect, // byte and length select
    input wire logic conversionStatus,    // high while converting
    input wire logic [11:0] dataOut,      // data lanes
    input wire logic [11:0] dataOe        // lane enables
);
    localparam int LONG_LEN = 12 * STEP_CYCLES + LEAD_CYCLES;
    localparam int SHORT_LEN = 8 * STEP_CYCLES + LEAD_CYCLES;
    logic [11:0] stsCnt_reg;
    logic [7:0] rcLowCnt_reg;
    logic startCond;
    logic readCond;
    assign startCond = chipActive & ~deviceSelN & ~readConvSel;
    assign readCond = chipActive & ~deviceSelN & readConvSel & ~conversionStatus;
    // counts status-high cycles so a whole conversion is judged at its end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stsCnt_reg <= 12'h000;
        end else if (conversionStatus) begin
            stsCnt_reg <= stsCnt_reg + 12'h001;
        end else begin
            stsCnt_reg <= 12'h000;
        end
    end
    // counts low cycles of read/convert so the whole pulse is judged when it ends
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rcLowCnt_reg <= 8'h00;
        end else if (readConvSel) begin
            rcLowCnt_reg <= 8'h00;
        end else if (rcLowCnt_reg != 8'hff) begin
            rcLowCnt_reg <= rcLowCnt_reg + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_status_length: assert property (
        $fell(conversionStatus) |-> stsCnt_reg == LONG_LEN || stsCnt_reg == SHORT_LEN)
        else $error("status high for a wrong number of cycles");
    a_start_status: assert property (
        $rose(startCond) && !conversionStatus |-> ##[1:4] conversionStatus)
        else $error("status did not rise after start");
    a_busy_released: assert property (
        conversionStatus [*8] |-> dataOe == 12'h000)
        else $error("lanes driven during conversion");
    a_lanes_stable: assert property (
        (|dataOe) && $past(|dataOe) |-> $stable(dataOut))
        else $error("data changed without an all-off gap");
    a_word_read: assert property (
        (readCond && wordWidthSel) [*4] |-> dataOe == 12'hfff)
        else $error("twelve-bit read not enabled");
    // a byte switch takes two sync stages, the all-off gap and the lane register
    a_byte_high: assert property (
        (readCond && !wordWidthSel && !byteAndLengthSelect) [*5] |-> dataOe == 12'hff0)
        else $error("upper byte lanes wrong");
    a_byte_low: assert property (
        (readCond && !wordWidthSel && byteAndLengthSelect) [*5]
        |-> dataOe == 12'h0ff && dataOut[7:4] == 4'h0)
        else $error("lower byte lanes wrong");
    a_read_hold: assert property (
        $fell(readConvSel) && (|dataOe) |-> ((|dataOe) || conversionStatus) [*6])
        else $error("data dropped too soon after convert");
    a_low_width: assert property (
        $rose(readConvSel) |-> rcLowCnt_reg >= 8'(`LOW_PULSE_CYC))
        else $error("convert pulse too short");
    c_short_conv: cover property ($fell(conversionStatus) && stsCnt_reg == SHORT_LEN);
    c_byte_low: cover property (readCond && !wordWidthSel && byteAndLengthSelect);
    c_hold: cover property ($fell(readConvSel) && (|dataOe));
endmodule
`default_nettype wire

// [test/adc_conversion_control_tb.sv]
// both ends joined on one link; random inputs against a bench model
// assumes the converter answers its comparator from the analog value set here
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_defs.svh"
module adc_conversion_control_tb;
    import adc_ctl_pkg::*;
    localparam int STEP = 8;
    logic core_clk, rstn, comparatorHigh, standAlone, shortConv, byteRead, startReq;
    logic convBusy, busy, resultValid;
    logic [11:0] trialCode, result, analog;
    logic [31:0] seed;
    int n_errors, n_tests, nValid;
    logic [11:0] expQ[$];
    adc_ctl_if link();
    adc_conversion_control #(.STEP_CYCLES(STEP), .DECIDE_CYCLES(STEP - 2))
        adc_conversion_control_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
        .comparatorHigh(comparatorHigh), .trialCode(trialCode), .convBusy(convBusy));
    adc_host_control adc_host_control_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
        .standAlone(standAlone), .shortConv(shortConv), .byteRead(byteRead),
        .startReq(startReq), .busy(busy), .result(result), .resultValid(resultValid));
    adc_ctl_checker #(.STEP_CYCLES(STEP), .LEAD_CYCLES(`LEAD_CYC)) adc_ctl_checker_inst (
        .core_clk(core_clk), .rstn(rstn), .chipActive(link.chipActive),
        .deviceSelN(link.deviceSelN), .readConvSel(link.readConvSel),
        .wordWidthSel(link.wordWidthSel), .byteAndLengthSelect(link.byteAndLengthSelect),
        .conversionStatus(link.conversionStatus), .dataOut(link.dataOut),
        .dataOe(link.dataOe));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one conversion plus a start pulse that must be ignored while busy
    task automatic run_one(input logic sa, input logic sh, input logic br);
        int waitCnt;
        @(posedge core_clk) #1;
        seed = xorshift(seed);
        analog = seed[11:0];
        standAlone = sa;
        shortConv = sh;
        byteRead = br;
        expQ.push_back((sh && !sa) ? {analog[11:4], 4'h8} : analog);
        startReq = 1'b1;
        @(posedge core_clk) #1;
        startReq = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 startReq = 1'b1;
        check("convBusy", {11'h000, convBusy}, 12'h001);
        @(posedge core_clk) #1;
        startReq = 1'b0;
        waitCnt = 0;
        while (resultValid !== 1'b1 && waitCnt < 3000) begin
            @(posedge core_clk) #1;
            waitCnt++;
        end
        if (waitCnt >= 3000) begin
            n_errors++;
            tally_and_finish();
        end
        check("result", result, expQ.pop_front());
        check("trialCode", trialCode, (sh && !sa) ? {analog[11:4], 4'h0} : analog);
        repeat (2) @(posedge core_clk);
        #1 check("busy", {11'h000, busy}, 12'h000);
    endtask
    always @(posedge core_clk) begin
        #1 comparatorHigh = (analog >= trialCode);
    end
    // look after the launching edge, while the one-cycle pulse stands
    always @(posedge core_clk) begin
        #1;
        if (resultValid === 1'b1) begin
            nValid++;
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // 16 conversions of at most about 165 cycles each; ample margin at 4 ns
    initial begin
        #80000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        rstn = 1'b0;
        standAlone = 1'b0;
        shortConv = 1'b0;
        byteRead = 1'b0;
        startReq = 1'b0;
        comparatorHigh = 1'b0;
        analog = 12'h000;
        seed = 32'd83;
        repeat (6) @(posedge core_clk);
        #1 rstn = 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 8; m++) begin
                run_one(m[2], m[1], m[0]);
                $display("test mode %0d round %0d done", m, r);
            end
            // reset in mid-run, then everything must work again
            @(posedge core_clk) #1 rstn = 1'b0;
            repeat (3) @(posedge core_clk);
            #1 rstn = 1'b1;
        end
        repeat (10) @(posedge core_clk);
        check("pulses", 12'(nValid), 12'h010);
        tally_and_finish();
    end
endmodule
`default_nettype wire
